// *** core/cct_defs.svh ***
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH
// Fixed costs of special sequences, in clock cycles and memory accesses
`define CCT_XEQ_CYC      8'd12
`define CCT_XEQ_ACC      8'd4
`define CCT_RESET_CYC    8'd36
`define CCT_RESET_ACC    8'd10
`define CCT_LOAD_CYC     8'd32
`define CCT_LOAD_ACC     8'd10
`define CCT_INTR_CYC     8'd32
`define CCT_INTR_ACC     8'd10
`define CCT_UNDEF_CYC    8'd8
`define CCT_UNDEF_ACC    8'd2
// Addressing-mode overhead
`define CCT_IND_CYC      8'd6
`define CCT_IND_ACC      8'd2
`define CCT_AINC_W_CYC   8'd12
`define CCT_AINC_B_CYC   8'd10
`define CCT_AINC_ACC     8'd4
`define CCT_SYM_CYC      8'd10
`define CCT_SYM_ACC      8'd2
`define CCT_IDX_CYC      8'd12
`define CCT_IDX_ACC      8'd4
// Divide base and per-step spread
`define CCT_DIV_BASE     8'd104
`define CCT_DIV_ACC      8'd12
`define CCT_DIV_STEPS    5'd16
// Memory cycle: two byte transfers, two clocks each
`define CCT_BYTE_CYC     8'd2
// Four-phase clock, reference phase 3 (index 2)
`define CCT_PHASES       2'd3
`define CCT_REF_PHASE    2'd2
// Mode field codes
`define CCT_MODE_REG     2'h0
`define CCT_MODE_IND     2'h1
`define CCT_MODE_SYM     2'h2
`define CCT_MODE_AINC    2'h3
// Undefined opcode ranges
`define CCT_UND_A_HI     16'h01FF
`define CCT_UND_B_LO     16'h0C00
`define CCT_UND_B_HI     16'h0FFF
`define CCT_UND_C_LO     16'h0780
`define CCT_UND_C_HI     16'h07FF
`define CCT_UND_D        16'h0320
`define CCT_UND_E        16'h033F
`endif

// *** core/cct_pkg.sv ***
package cct_pkg;
  // Kind of sequence being timed
  typedef enum logic [2:0] {
    CCT_OP_NORMAL,
    CCT_OP_DIVIDE,
    CCT_OP_EXECUTE,
    CCT_OP_RESET,
    CCT_OP_LOAD,
    CCT_OP_INTR
  } cct_op_t;
  // Sequencer state
  typedef enum logic [1:0] {
    CCT_IDLE,
    CCT_BUSY,
    CCT_MEM
  } cct_state_t;
endpackage : cct_pkg

// *** core/cct_phase_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Four-phase timing shared by the sequencer and the phase generator
interface cct_phase_if;
  logic [1:0] phase;     // Current phase index 0..3
  logic       ref_tick;  // High in the reference phase
  logic       sys_tick;  // One system clock per four input clocks
  modport gen (output phase, output ref_tick, output sys_tick);
  modport use_side (input phase, input ref_tick, input sys_tick);
endinterface : cct_phase_if
`default_nettype wire

// *** core/cct_phase_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
// Divides the input clock into four phases of one input period each
module cct_phase_gen (
  input wire logic   clk,
  input wire logic   reset,
  cct_phase_if.gen   ph
);
  logic [1:0] phase_reg;  // Phase counter
  logic [1:0] phase_next;

  assign phase_next = (phase_reg == `CCT_PHASES) ? 2'h0 : phase_reg + 2'h1;

  // Free-running phase counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign ph.phase    = phase_reg;
  assign ph.ref_tick = (phase_reg == `CCT_REF_PHASE);
  assign ph.sys_tick = (phase_reg == `CCT_PHASES);

  phase_wrap_a: assert property (@(posedge clk) disable iff (reset)
    (phase_reg == `CCT_PHASES) |=> (phase_reg == 2'h0))
    else $error("phase counter did not wrap after phase 4");
endmodule : cct_phase_gen
`default_nettype wire

// *** core/cct_timing.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cct_defs.svh"
// Functional notes
// - Divide time varies with partial quotient bits
// - Execute-other costs 12 cycles, 4 accesses, plus target
// - Reset sequence takes 36 cycles, 10 accesses
// - Interrupt switch takes 32 cycles, 10 accesses
// - Undefined opcodes cost 8 cycles, 2 accesses
// - Word addressing-mode overhead per mode table
// - Byte auto-increment adds 10 cycles, 4 accesses
// - Input clock four times system, four phases
// - External samples and changes on phase 3; bus_strobe here comes one clock later, in phase 4
// - Time equals cycles plus waits times accesses
// - Word access is two bytes, MSB first
module cct_timing
  import cct_pkg::*;
(
  input  wire logic        clk,                  // Input clock, four per system clock
  input  wire logic        reset,                // Asynchronous, active high
  input  wire logic        start,                // Begin timing one sequence
  input  wire cct_pkg::cct_op_t op_kind,         // What sequence to time
  input  wire logic [15:0] opcode,               // Instruction word
  input  wire logic [7:0]  base_cycles,          // Table cycle count, all-register form
  input  wire logic [7:0]  base_accesses,        // Table access count
  input  wire logic        byte_op,              // Byte operand selects byte table
  input  wire logic [1:0]  src_mode,             // Source mode field
  input  wire logic        src_reg_zero,         // Source register field is zero
  input  wire logic [1:0]  dst_mode,             // Destination mode field
  input  wire logic        dst_reg_zero,         // Destination register field is zero
  input  wire logic        dst_used,             // Destination operand present
  input  wire logic [15:0] div_quotient,         // Partial quotient bits of a divide
  input  wire logic [3:0]  wait_states,          // Wait states per memory access
  input  wire logic [2:0]  interrupt_code_lines, // May change asynchronously
  output var  logic        busy,                 // Sequence in progress
  output var  logic        done,                 // One-cycle pulse at sequence end
  output var  logic [11:0] total_cycles,         // Cycles charged, waits included
  output var  logic [7:0]  accesses,             // Memory accesses charged
  output var  logic        undefined_op,         // Last opcode was undefined
  output var  logic        bus_low_byte,         // Byte lane: 0 MSB, 1 LSB
  output var  logic        bus_strobe,           // Byte transfer, one clock after reference phase
  output var  logic [2:0]  int_code_sync         // Synchronised interrupt code
);
  cct_phase_if ph ();

  cct_phase_gen u_phase (
    .clk   (clk),
    .reset (reset),
    .ph    (ph)
  );

  // Overhead of one operand's mode: returns {cycles, accesses}
  function automatic logic [15:0] mode_cost(input logic [1:0] m, input logic rz,
                                            input logic bt);
    logic [15:0] r;
    r = 16'h0000;
    if (m == `CCT_MODE_IND) begin
      r = {`CCT_IND_CYC, `CCT_IND_ACC};
    end else if (m == `CCT_MODE_AINC) begin
      r = {(bt ? `CCT_AINC_B_CYC : `CCT_AINC_W_CYC), `CCT_AINC_ACC};
    end else if (m == `CCT_MODE_SYM) begin
      r = rz ? {`CCT_SYM_CYC, `CCT_SYM_ACC} : {`CCT_IDX_CYC, `CCT_IDX_ACC};
    end
    return r;
  endfunction : mode_cost

  // Count of set bits, used for divide step spread
  function automatic logic [4:0] ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : ones

  // Opcode decode
  wire logic is_undef;
  assign is_undef = (opcode <= `CCT_UND_A_HI) ||
                    (opcode >= `CCT_UND_B_LO && opcode <= `CCT_UND_B_HI) ||
                    (opcode >= `CCT_UND_C_LO && opcode <= `CCT_UND_C_HI) ||
                    (opcode == `CCT_UND_D) || (opcode == `CCT_UND_E);

  wire logic [15:0] src_cost;
  wire logic [15:0] dst_cost;
  assign src_cost = mode_cost(src_mode, src_reg_zero, byte_op);
  assign dst_cost = dst_used ? mode_cost(dst_mode, dst_reg_zero, byte_op) : 16'h0000;

  // Divide: two cycles per set quotient bit within the 104..136 span
  wire logic [7:0] div_cyc;
  assign div_cyc = `CCT_DIV_BASE + {2'h0, ones(div_quotient), 1'b0};

  // Cycle and access charge for the requested sequence
  logic [7:0] c_sel;
  logic [7:0] m_sel;
  always_comb begin
    c_sel = base_cycles + src_cost[15:8] + dst_cost[15:8];
    m_sel = base_accesses + src_cost[7:0] + dst_cost[7:0];
    case (op_kind)
      CCT_OP_RESET: begin
        c_sel = `CCT_RESET_CYC;
        m_sel = `CCT_RESET_ACC;
      end
      CCT_OP_LOAD: begin
        c_sel = `CCT_LOAD_CYC;
        m_sel = `CCT_LOAD_ACC;
      end
      CCT_OP_INTR: begin
        c_sel = `CCT_INTR_CYC;
        m_sel = `CCT_INTR_ACC;
      end
      CCT_OP_EXECUTE: begin
        // Target instruction's own time is charged by its own start
        c_sel = `CCT_XEQ_CYC + src_cost[15:8];
        m_sel = `CCT_XEQ_ACC + src_cost[7:0];
      end
      CCT_OP_DIVIDE: begin
        c_sel = div_cyc + src_cost[15:8];
        m_sel = `CCT_DIV_ACC + src_cost[7:0];
      end
      default: begin
        if (is_undef) begin
          c_sel = `CCT_UNDEF_CYC;
          m_sel = `CCT_UNDEF_ACC;
        end
      end
    endcase
  end

  wire logic undef_now;
  assign undef_now = (op_kind == CCT_OP_NORMAL) && is_undef;

  // Total time in clocks: C + W*M, each access being two byte transfers
  wire logic [11:0] total_next;
  // Both factors widened first so the product keeps all twelve bits
  assign total_next = {4'h0, c_sel} + ({4'h0, m_sel} * {8'h00, wait_states});

  // Sequencer registers
  cct_state_t  state_reg, state_next;
  logic [11:0] cnt_reg;       // Clocks left in the sequence
  logic [11:0] total_reg;
  logic [7:0]  acc_reg;
  logic        undef_reg;
  logic        done_reg;
  logic        lane_reg;      // Byte lane, toggles per transfer
  logic        strobe_reg;
  logic        busy_reg;      // Busy output straight from a flop
  logic [2:0]  ic_meta_reg;   // First stage, read only by the second
  logic [2:0]  ic_sync_reg;

  wire logic last;
  assign last = (state_reg == CCT_BUSY) && (cnt_reg == 12'h001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CCT_IDLE: begin
        if (start) begin
          state_next = CCT_BUSY;
        end
      end
      CCT_BUSY: begin
        if (last) begin
          state_next = CCT_IDLE;
        end
      end
      default: begin
        state_next = CCT_IDLE;
      end
    endcase
  end

  // State and counter; one clock per count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= CCT_IDLE;
      busy_reg  <= 1'b0;
      cnt_reg   <= 12'h000;
      total_reg <= 12'h000;
      acc_reg   <= 8'h00;
      undef_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next == CCT_BUSY);
      if (state_reg == CCT_IDLE && start) begin
        cnt_reg   <= (total_next == 12'h000) ? 12'h001 : total_next;
        total_reg <= total_next;
        acc_reg   <= m_sel;
        undef_reg <= undef_now;
      end else if (state_reg == CCT_BUSY) begin
        cnt_reg <= cnt_reg - 12'h001;
      end
    end
  end

  // End pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= last;
    end
  end

  // Byte transfers one clock after the reference phase: MSB lane first, then LSB
  // Lane advances after each strobe, so the first strobe of a sequence shows MSB
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lane_reg   <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= (state_reg == CCT_BUSY) && ph.ref_tick;
      if (state_reg != CCT_BUSY) begin
        lane_reg <= 1'b0;
      end else if (strobe_reg) begin
        lane_reg <= ~lane_reg;
      end
    end
  end

  // Interrupt code lines are the only inputs taken through a two-flop synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ic_meta_reg <= 3'h0;
      ic_sync_reg <= 3'h0;
    end else begin
      ic_meta_reg <= interrupt_code_lines;
      ic_sync_reg <= ic_meta_reg;
    end
  end

  assign busy          = busy_reg;
  assign done          = done_reg;
  assign total_cycles  = total_reg;
  assign accesses      = acc_reg;
  assign undefined_op  = undef_reg;
  assign bus_low_byte  = lane_reg;
  assign bus_strobe    = strobe_reg;
  assign int_code_sync = ic_sync_reg;

  reset_cost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && op_kind == CCT_OP_RESET && wait_states == 4'h0)
    |=> (total_reg == 12'd36 && acc_reg == 8'd10))
    else $error("reset sequence cost wrong");

  load_cost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && op_kind == CCT_OP_LOAD && wait_states == 4'h0)
    |=> (total_reg == 12'd32 && acc_reg == 8'd10))
    else $error("load sequence cost wrong");

  intr_cost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && op_kind == CCT_OP_INTR)
    |=> (acc_reg == 8'd10))
    else $error("interrupt switch access count wrong");

  undef_cost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && undef_now && wait_states == 4'h0)
    |=> (undefined_op && total_reg == 12'd8 ##8 done))
    else $error("undefined opcode not done in 8 cycles");

  xeq_cost_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && op_kind == CCT_OP_EXECUTE && src_mode == 2'h0)
    |=> (acc_reg == 8'd4))
    else $error("execute-other access count wrong");

  div_span_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start && op_kind == CCT_OP_DIVIDE && src_mode == 2'h0 &&
     wait_states == 4'h0) |=> (total_reg >= 12'd104 && total_reg <= 12'd136))
    else $error("divide time out of span");

  byte_ainc_a: assert property (@(posedge clk) disable iff (reset)
    (byte_op && src_mode == 2'h3) |-> (src_cost == {8'd10, 8'd4}))
    else $error("byte auto-increment overhead wrong");

  word_idx_a: assert property (@(posedge clk) disable iff (reset)
    (src_mode == 2'h2 && !src_reg_zero) |-> (src_cost == {8'd12, 8'd4}))
    else $error("indexed overhead wrong");

  lane_order_a: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> !bus_low_byte)
    else $error("transfer did not start on high byte");

  wait_time_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == CCT_IDLE && start) |=> (total_reg >= {4'h0, $past(c_sel)}))
    else $error("total time below base cycles");
endmodule : cct_timing
`default_nettype wire

// *** test/cct_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Far side: supplies wait states and interrupt code, watches byte strobes
module cct_mem_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       busy,
  input  wire logic       bus_strobe,
  input  wire logic       bus_low_byte,
  input  wire logic [3:0] wait_cfg,
  input  wire logic [2:0] code_cfg,
  output var  logic [3:0] wait_states,
  output var  logic [2:0] interrupt_code_lines,
  output var  int         err_cnt,
  output var  int         seen_cnt
);
  int   gap_reg;  // Clocks since the last byte strobe
  logic lane_exp; // Lane the next strobe must show
  // Wait states change only on the clock edge
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_states <= 4'h0;
    end else begin
      wait_states <= wait_cfg;
    end
  end
  // Interrupt code moves mid-period, unrelated to the clock; one process drives it
  initial begin
    interrupt_code_lines = 3'h0;
    forever begin
      @(code_cfg);
      interrupt_code_lines <= #7 code_cfg;
    end
  end
  // Strobes sit on one phase, four apart; lanes pair MSB then LSB
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_reg  <= 0;
      lane_exp <= 1'b0;
      err_cnt  <= 0;
      seen_cnt <= 0;
    end else if (bus_strobe) begin
      seen_cnt <= seen_cnt + 1;
      if ((gap_reg != 0 && gap_reg % 4 != 0) || bus_low_byte !== lane_exp) begin
        err_cnt <= err_cnt + 1;
      end
      gap_reg  <= 1;
      lane_exp <= busy ? ~lane_exp : 1'b0;
    end else begin
      if (gap_reg != 0) begin
        gap_reg <= gap_reg + 1;
      end
      if (!busy) begin
        lane_exp <= 1'b0;
      end
    end
  end
endmodule : cct_mem_model
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cct_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  cct_op_t     op_kind = CCT_OP_NORMAL;
  logic [15:0] opcode = 16'hA000;
  logic [7:0]  base_cycles = 8'h16;   // All-register form of a two-operand op
  logic [7:0]  base_accesses = 8'h08;
  logic        byte_op = 1'b0;
  logic [1:0]  src_mode = 2'h0;
  logic        src_reg_zero = 1'b0;
  logic [1:0]  dst_mode = 2'h0;
  logic        dst_reg_zero = 1'b0;
  logic        dst_used = 1'b0;
  logic [15:0] div_quotient = 16'h0000;
  logic [3:0]  wait_cfg = 4'h0;
  logic [2:0]  code_cfg = 3'h0;
  logic [3:0]  wait_states;
  logic [2:0]  interrupt_code_lines;
  logic        busy, done, undefined_op, bus_low_byte, bus_strobe;
  logic [11:0] total_cycles;
  logic [7:0]  accesses;
  logic [2:0]  int_code_sync;
  int          err_cnt, seen_cnt;
  int          bad_count = 0;
  int          check_count = 0;
  // 50 MHz input clock
  always #10 clk = ~clk;
  cct_timing i_dut (.clk(clk), .reset(reset), .start(start), .op_kind(op_kind),
    .opcode(opcode), .base_cycles(base_cycles), .base_accesses(base_accesses),
    .byte_op(byte_op), .src_mode(src_mode), .src_reg_zero(src_reg_zero),
    .dst_mode(dst_mode), .dst_reg_zero(dst_reg_zero), .dst_used(dst_used),
    .div_quotient(div_quotient), .wait_states(wait_states),
    .interrupt_code_lines(interrupt_code_lines), .busy(busy), .done(done),
    .total_cycles(total_cycles), .accesses(accesses), .undefined_op(undefined_op),
    .bus_low_byte(bus_low_byte), .bus_strobe(bus_strobe), .int_code_sync(int_code_sync));
  cct_mem_model i_mem (.clk(clk), .reset(reset), .bus_strobe(bus_strobe),
    .busy(busy), .bus_low_byte(bus_low_byte),
    .wait_cfg(wait_cfg), .code_cfg(code_cfg), .wait_states(wait_states),
    .interrupt_code_lines(interrupt_code_lines), .err_cnt(err_cnt), .seen_cnt(seen_cnt));
  // Verdict and end of run
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Four-state compare; an unknown matches only the same unknown in exp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Wait states reach the pins one edge after the model sees them
  task automatic cfg_wait(input logic [3:0] w);
    @(posedge clk);
    wait_cfg <= w;
    @(posedge clk);
  endtask : cfg_wait
  // One timed sequence; poke raises a second request while busy
  task automatic run(input cct_op_t k, input logic [11:0] ec, input logic [7:0] em,
                     input logic eu, input bit poke);
    int n;
    @(posedge clk);
    op_kind <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1 chk(busy, 1'b1);
    if (poke) begin
      @(posedge clk);
      op_kind <= CCT_OP_INTR;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
    end
    n = 0;
    // Bounded wait for the end pulse
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
    end else begin
      chk(total_cycles, ec);
      chk(accesses, em);
      chk(undefined_op, eu);
    end
  endtask : run
  // Extra cycles and accesses of one mode; 2 symbolic, 3 indexed
  function automatic logic [15:0] mcost(input int md, input bit b);
    case (md)
      1: return 16'h0602;
      2: return 16'h0A02;
      3: return 16'h0C04;
      4: return b ? 16'h0A04 : 16'h0C04;
      default: return 16'h0000;
    endcase
  endfunction : mcost
  function automatic logic [1:0] enc(input int md);
    return (md == 0) ? 2'h0 : (md == 1) ? 2'h1 : (md == 4) ? 2'h3 : 2'h2;
  endfunction : enc
  // Fixed sequences, with and without wait states, one refused request per wait setting
  task automatic t_special;
    for (int w = 0; w < 4; w += 3) begin
      cfg_wait(w[3:0]);
      run(CCT_OP_RESET, 12'h024 + 12'h00A * w[11:0], 8'h0A, 1'b0, 1'b1);
      run(CCT_OP_LOAD, 12'h020 + 12'h00A * w[11:0], 8'h0A, 1'b0, 1'b0);
      run(CCT_OP_INTR, 12'h020 + 12'h00A * w[11:0], 8'h0A, 1'b0, 1'b0);
    end
  endtask : t_special
  // Every undefined range edge and single code, then defined neighbours
  task automatic t_undef;
    logic [15:0] ops [12] = '{16'h0000, 16'h01FF, 16'h0C00, 16'h0FFF, 16'h0780, 16'h07FF,
                              16'h0320, 16'h033F, 16'h0200, 16'h0BFF, 16'h077F, 16'h0321};
    logic [11:0] e_un;
    logic [11:0] e_df;
    // No wait states first, then two per access
    for (int w = 0; w < 3; w += 2) begin
      cfg_wait(w[3:0]);
      e_un = 12'h008 + 12'h002 * w[11:0];
      e_df = 12'h016 + 12'h008 * w[11:0];
      for (int i = 0; i < 12; i++) begin
        @(posedge clk);
        opcode <= ops[i];
        if (i < 8) run(CCT_OP_NORMAL, e_un, 8'h02, 1'b1, 1'b0);
        else run(CCT_OP_NORMAL, e_df, 8'h08, 1'b0, 1'b0);
      end
    end
  endtask : t_undef
  // Each mode on source then destination, word and byte, one wait state
  task automatic t_modes;
    logic [15:0] c;
    logic [11:0] et;
    cfg_wait(4'h1);
    for (int b = 0; b < 2; b++) begin
      for (int md = 0; md < 5; md++) begin
        for (int d = 0; d < 2; d++) begin
          c = mcost(md, b[0]);
          @(posedge clk);
          byte_op <= b[0];
          src_mode <= d ? 2'h0 : enc(md);
          dst_mode <= d ? enc(md) : 2'h0;
          src_reg_zero <= (md == 2);
          dst_reg_zero <= (md == 2);
          dst_used <= 1'b1;
          et = 12'h01E + c[15:8] + c[7:0];
          run(CCT_OP_NORMAL, et, 8'h08 + c[7:0], 1'b0, 1'b0);
        end
      end
    end
  endtask : t_modes
  // Execute-other with each source mode
  task automatic t_exec;
    logic [15:0] c;
    cfg_wait(4'h0);
    for (int md = 0; md < 5; md++) begin
      c = mcost(md, 1'b0);
      @(posedge clk);
      byte_op <= 1'b0;
      src_mode <= enc(md);
      src_reg_zero <= (md == 2);
      run(CCT_OP_EXECUTE, 12'h00C + c[15:8], 8'h04 + c[7:0], 1'b0, 1'b0);
    end
  endtask : t_exec
  // Divide time follows the quotient bits
  task automatic t_div;
    logic [15:0] qs [4] = '{16'h0000, 16'hFFFF, 16'h0001, 16'hA5A5};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src_mode <= 2'h0;
      div_quotient <= qs[i];
      run(CCT_OP_DIVIDE, 12'h068 + 12'($countones(qs[i])) * 12'h002, 8'h0C, 1'b0, 1'b0);
    end
  endtask : t_div
  // Every interrupt code crosses the synchroniser
  task automatic t_int;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      code_cfg <= c[2:0];
      repeat (4) @(posedge clk);
      #1 chk(int_code_sync, c[2:0]);
    end
  endtask : t_int
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_special();
    t_undef();
    t_modes();
    t_exec();
    t_div();
    t_int();
    chk(err_cnt[15:0], 16'h0000);
    chk(seen_cnt != 0, 1'b1);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
